// file: design/capture_compare_unit.v
// Capture/compare unit with AXI4-Lite register slave and one event pin.
// Assumes the timebase runs on aclk; timebase_run is low in sleep.
`include "capture_compare_consts.vh"

// How it works
// (R1) One 16-bit value register, three uses.
// (R2) Mode zero turns off, resets internals.
// (R3) Capture modes: fall, rise, 4th, 16th rise.
// (R4) Mode 1000: pin low, high on match.
// (R5) Mode 1001: pin high, low on match.
// (R6) Mode 1010: flag only, pin untouched.
// (R7) Mode 1011 triggers special event; 11xx PWM.
// (R8) Control bits 5:4 hold duty LSBs.
// (R9) Control bits 7:6 read as zero.
// (R10) Capture loads full timebase into value.
// (R11) Capture sets sticky flag; software clears.
// (R12) New capture overwrites unread value.
// (R13) Capture leaves the timebase counting.
// (R14) Software runs timebase in synchronous mode.
// (R15) Edge detect ignores pin direction.
// (R16) Software masks and clears flag around changes.
// (R17) Prescaler cleared when not capturing.
// (R18) Prescale switches keep prescaler count.
// (R19) Sleep: prescaler counts, timebase halts.
// (R20) Sleep capture sets flag, not value.
// (R21) Reset turns unit off, prescaler zero.
// (R22) Compare match acts and flags together.
// (R23) Modes 1000 and 1001 preset latch; clear forces low.
// (R24) Special trigger resets timebase, no overflow.
// (R25) Pin synchronised on every path, prescaling in sleep too.

module capture_compare_unit
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [15:0] timebase_count,
  input  wire        timebase_run,
  input  wire        event_irq_enable,
  input  wire        event_pin_in,
  output wire        event_pin_out,
  output wire        event_pin_oe_n,
  output wire        special_trigger,
  output wire        wake_request,
  output wire        event_flag,
  output wire [9:0]  pwm_duty
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [`CTRL_WIDTH-1:0] ctrl_r;
  reg  [15:0]            value_r;
  reg                    flag_r;
  reg                    latch_r;
  reg                    drive_r;
  reg                    trig_r;
  reg  [3:0]             presc_r;
  reg                    pin_s1_r;
  reg                    pin_s2_r;
  reg                    pin_prev_r;
  reg                    raw_prev_r;
  reg                    aw_held_r;
  reg  [3:0]             aw_addr_r;
  reg                    w_held_r;
  reg  [31:0]            w_data_r;
  reg  [3:0]             w_strb_r;
  reg                    bvalid_r;
  reg  [1:0]             bresp_r;
  reg                    rvalid_r;
  reg  [31:0]            rdata_r;
  reg  [1:0]             rresp_r;

  wire [3:0] mode = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];

  function is_capture;
    input [3:0] m;
    begin
      is_capture = (m[3:2] == 2'h1);
    end
  endfunction

  function is_pin_compare;
    input [3:0] m;
    begin
      is_pin_compare = (m == `MODE_CMP_SET) || (m == `MODE_CMP_CLR);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ----------------------------------------------------------------
  // The pin level is read whatever its direction, so software driving
  // the pin as an output can cause captures.
  always @(posedge aclk)
  begin
    pin_s1_r   <= event_pin_in;                               // (R25)
    pin_s2_r   <= pin_s1_r;
    pin_prev_r <= pin_s2_r;
  end

  wire rise_sync = pin_s2_r & ~pin_prev_r;                    // (R15)
  wire fall_sync = ~pin_s2_r & pin_prev_r;

  // The sleep path uses the same synchronised level as the awake path.
  always @(posedge aclk)
  begin
    raw_prev_r <= pin_s2_r;
  end
  wire rise_ev = timebase_run ? rise_sync : (pin_s2_r & ~raw_prev_r);
  wire fall_ev = timebase_run ? fall_sync : (~pin_s2_r & raw_prev_r);

  // ----------------------------------------------------------------
  // Capture event selection and prescaler
  // ----------------------------------------------------------------
  reg cap_event;
  always @*
  begin
    cap_event = 1'b0;
    case (mode)
      `MODE_CAP_FALL:   cap_event = fall_ev;                  // (R3)
      `MODE_CAP_RISE:   cap_event = rise_ev;
      `MODE_CAP_RISE4:  cap_event = rise_ev &&
                          (presc_r[1:0] == `PRESCALE_4_LAST);
      `MODE_CAP_RISE16: cap_event = rise_ev &&
                          (presc_r == `PRESCALE_16_LAST);
      default:          cap_event = 1'b0;
    endcase
  end

  // The counter is shared by the 4 and 16 settings and is not cleared
  // when switching between them.
  always @(posedge aclk)
  begin
    if (!aresetn || !is_capture(mode))                        // (R17) (R21)
      presc_r <= 4'h0;
    else if (rise_ev)                                         // (R18) (R19)
      presc_r <= presc_r + 4'h1;
  end

  // ----------------------------------------------------------------
  // Compare logic
  // ----------------------------------------------------------------
  wire is_compare = (mode[3:2] == 2'h2);
  wire match      = is_compare && (value_r == timebase_count); // (R22)

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;

  wire       aw_take = s_axi_awvalid & s_axi_awready;
  wire       w_take  = s_axi_wvalid & s_axi_wready;
  wire       aw_ok   = aw_held_r | aw_take;
  wire       w_ok    = w_held_r | w_take;
  wire       do_wr   = aw_ok & w_ok;
  wire [3:0] wa      = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd     = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0] ws      = w_held_r ? w_strb_r : s_axi_wstrb;

  wire wr_ctrl  = do_wr && (wa == `ADDR_MODE_CONTROL) && ws[0];
  wire wr_low   = do_wr && (wa == `ADDR_VALUE_LOW) && ws[0];
  wire wr_high  = do_wr && (wa == `ADDR_VALUE_HIGH) && ws[0];
  wire wr_stat  = do_wr && (wa == `ADDR_STATUS) && ws[0];
  wire wr_known = (wa == `ADDR_MODE_CONTROL) || (wa == `ADDR_VALUE_LOW) ||
                  (wa == `ADDR_VALUE_HIGH) || (wa == `ADDR_STATUS);

  wire [3:0] new_mode = wd[`CTRL_MODE_MSB:`CTRL_MODE_LSB];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end
    else
    begin
      if (do_wr)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take)
        begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
          bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ----------------------------------------------------------------
  // Control, value, flag and pin latch
  // ----------------------------------------------------------------
  wire cap_load = cap_event && timebase_run;                  // (R20)

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r  <= {`CTRL_WIDTH{1'b0}};                         // (R21)
      value_r <= 16'h0000;
      flag_r  <= 1'b0;
      latch_r <= 1'b0;
      drive_r <= 1'b0;
      trig_r  <= 1'b0;
    end
    else
    begin
      trig_r <= match && (mode == `MODE_CMP_TRIG);            // (R7) (R24)
      if (wr_ctrl)
      begin
        ctrl_r <= wd[`CTRL_WIDTH-1:0];                        // (R8) (R9)
        if (new_mode == `MODE_OFF)
        begin
          latch_r <= 1'b0;                                    // (R2) (R23)
          drive_r <= 1'b0;
        end
        else if (new_mode == `MODE_CMP_SET)
        begin
          latch_r <= 1'b0;                                    // (R4) (R23)
          drive_r <= 1'b1;
        end
        else if (new_mode == `MODE_CMP_CLR)
        begin
          latch_r <= 1'b1;                                    // (R5) (R23)
          drive_r <= 1'b1;
        end
        else if (!is_pin_compare(new_mode))
          drive_r <= 1'b0;                                    // (R6)
      end
      else if (match && (mode == `MODE_CMP_SET))
        latch_r <= 1'b1;                                      // (R4)
      else if (match && (mode == `MODE_CMP_CLR))
        latch_r <= 1'b0;                                      // (R5)

      // A capture overwrites the value even if unread.
      if (cap_load)
        value_r <= timebase_count;                            // (R1) (R10) (R12) (R13)
      else
      begin
        if (wr_low)
          value_r[7:0] <= wd[7:0];
        if (wr_high)
          value_r[15:8] <= wd[7:0];
      end

      // Hardware set wins over a software clear in the same cycle.
      if (cap_event || match)
        flag_r <= 1'b1;                                       // (R11) (R22)
      else if (wr_stat && wd[`STAT_EVENT_FLAG])
        flag_r <= 1'b0;
    end
  end

  assign event_pin_out   = latch_r;
  assign event_pin_oe_n  = ~drive_r;
  assign special_trigger = trig_r;
  assign event_flag      = flag_r;
  assign wake_request    = flag_r & event_irq_enable & ~timebase_run; // (R20)
  assign pwm_duty        = {value_r[7:0],
                            ctrl_r[`CTRL_DUTY_MSB:`CTRL_DUTY_LSB]};  // (R8)

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~rvalid_r;

  reg [31:0] rd_val;
  reg [1:0]  rd_resp;
  always @*
  begin
    rd_val  = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    case (s_axi_araddr)
      `ADDR_MODE_CONTROL: rd_val = {26'h0, ctrl_r};           // (R9)
      `ADDR_VALUE_LOW:    rd_val = {24'h0, value_r[7:0]};
      `ADDR_VALUE_HIGH:   rd_val = {24'h0, value_r[15:8]};
      `ADDR_STATUS:       rd_val = {30'h0, pin_s2_r, flag_r};
      default:            rd_resp = `RESP_SLVERR;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_resp;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule // capture_compare_unit

// file: inc/capture_compare_consts.vh
// Constants for the capture/compare unit: register map, fields, modes.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`ifndef CAPTURE_COMPARE_CONSTS_VH
`define CAPTURE_COMPARE_CONSTS_VH

`define ADDR_MODE_CONTROL   4'h0
`define ADDR_VALUE_LOW      4'h4
`define ADDR_VALUE_HIGH     4'h8
`define ADDR_STATUS         4'hC

`define MODE_OFF            4'h0
`define MODE_CAP_FALL       4'h4
`define MODE_CAP_RISE       4'h5
`define MODE_CAP_RISE4      4'h6
`define MODE_CAP_RISE16     4'h7
`define MODE_CMP_SET        4'h8
`define MODE_CMP_CLR        4'h9
`define MODE_CMP_SOFT       4'hA
`define MODE_CMP_TRIG       4'hB

`define CTRL_MODE_LSB       0
`define CTRL_MODE_MSB       3
`define CTRL_DUTY_LSB       4
`define CTRL_DUTY_MSB       5
`define CTRL_WIDTH          6

`define STAT_EVENT_FLAG     0
`define STAT_PIN_LEVEL      1

`define PRESCALE_4_LAST     4'h3
`define PRESCALE_16_LAST    4'hF

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: verif/capture_compare_unit_sva.sv
// Checker for the capture/compare unit, bound to its top module.
// Assumes one clock, aclk, and a synchronous active-low reset.
module capture_compare_unit_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic timebase_run,
  input wire logic event_irq_enable,
  input wire logic event_flag,
  input wire logic wake_request,
  input wire logic special_trigger,
  input wire logic event_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data missing");
  AST_WAKE: assert property (wake_request == (event_flag &&
    event_irq_enable && !timebase_run)) else $error("wake level wrong");
  AST_TRIG_PULSE: assert property (special_trigger |=>
    !special_trigger) else $error("trigger longer than one cycle");
  AST_TRIG_FLAG: assert property (special_trigger |-> event_flag)
    else $error("trigger without flag");
  AST_FLAG_STICKY: assert property ($fell(event_flag) |->
    $rose(s_axi_bvalid)) else $error("flag cleared without a write");
  AST_RESET_OFF: assert property (disable iff (1'h0) !aresetn |=>
    event_pin_oe_n && !event_flag && !special_trigger)
    else $error("unit not off after reset");
  cover property (special_trigger);
  cover property (wake_request);
  cover property ($fell(event_pin_oe_n));
endmodule  // capture_compare_unit_sva

bind capture_compare_unit capture_compare_unit_sva u_sva (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .timebase_run(timebase_run), .event_irq_enable(event_irq_enable),
  .event_flag(event_flag), .wake_request(wake_request),
  .special_trigger(special_trigger), .event_pin_oe_n(event_pin_oe_n));

// file: verif/pin_source_model.sv
// Far-side model of the event pin: a signal source or a load.
// Assumes the unit's output enable is active low.
module pin_source_model
(
  input  wire logic aclk,
  input  wire logic event_pin_out,
  input  wire logic event_pin_oe_n,
  input  wire logic src_en,
  input  wire logic src_level,
  output wire logic event_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r;
  // A released line holds the inverse of the last level driven onto it.
  always @(posedge aclk)
    if (!event_pin_oe_n || src_en)
      last_r <= event_pin_in;
  assign event_pin_in = !event_pin_oe_n ? event_pin_out :
                        src_en ? src_level : ~last_r;
endmodule  // pin_source_model

// file: verif/tb_top.sv
// Testbench for the capture/compare unit: AXI4-Lite master and timebase.
// Assumes the pin model in pin_source_model and the bound checker.
`include "capture_compare_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic        run, irq, load, src_en, lvl;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata;
  logic [15:0] tcount, base, v, old;
  wire         awready, wready, bvalid, arready, rvalid, pin, pout, oe_n;
  wire         trig, wake, flag;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [9:0]   duty;
  logic [1:0]  bq[$];
  logic [31:0] rq[$];
  int          err_total, n_tests, trigs, n;

  capture_compare_unit dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timebase_count(tcount),
    .timebase_run(run), .event_irq_enable(irq), .event_pin_in(pin),
    .event_pin_out(pout), .event_pin_oe_n(oe_n), .special_trigger(trig),
    .wake_request(wake), .event_flag(flag), .pwm_duty(duty));
  pin_source_model src (.aclk(aclk), .event_pin_out(pout),
    .event_pin_oe_n(oe_n), .src_en(src_en), .src_level(lvl),
    .event_pin_in(pin));

  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Timebase owner and response monitor
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (trig) trigs <= trigs + 1;
    if (load) tcount <= base;
    else if (trig) tcount <= 16'h0000;
    else if (run) tcount <= tcount + 16'h0001;
  end
  always @(posedge aclk)
  begin
    if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
    if (rvalid && rready) chk("rdata", rq.pop_front(), rdata);
    if (rvalid && rready) chk("rresp", `RESP_OKAY, rresp);
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d,
    logic [1:0] r = `RESP_OKAY);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
  endtask
  task automatic pulse(int k);
    repeat (k)
    begin
      lvl <= 1'h1;
      repeat (6) @(posedge aclk);
      lvl <= 1'h0;
      repeat (6) @(posedge aclk);
    end
  endtask
  task automatic setmode(logic [31:0] m);
    wr(`ADDR_MODE_CONTROL, 32'h0);
    wr(`ADDR_MODE_CONTROL, m);
    wr(`ADDR_STATUS, 32'h1);
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    conclude;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, irq, load, lvl} = 7'h00;
    {run, src_en, bready, rready} = 4'hF;
    {awaddr, araddr, wstrb, wdata} = {8'h00, 4'hF, 32'h0};
    {tcount, base, old, trigs, err_total, n_tests} = {32'h0, 16'h00AB, 96'h0};
    void'($urandom(32'h2E57));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`ADDR_MODE_CONTROL, 32'h0);
    wr(`ADDR_VALUE_LOW, 32'hAB);
    wr(`ADDR_MODE_CONTROL, 32'hFF);
    wr(4'h2, 32'h0, `RESP_SLVERR);
    rd(`ADDR_MODE_CONTROL, 32'h3F);
    chk("duty", 32'h2AF, {22'h0, duty});
    for (int m = 4; m < 8; m++)
    begin
      setmode(m);
      n = m == 6 ? 4 : m == 7 ? 16 : 1;
      v = 16'($urandom);
      base <= ~old;
      load <= 1'h1;
      pulse(n - 1);
      rd(`ADDR_VALUE_LOW, {24'h0, old[7:0]});
      base <= v;
      pulse(1);
      repeat (6) @(posedge aclk);
      rd(`ADDR_VALUE_LOW, {24'h0, v[7:0]});
      rd(`ADDR_VALUE_HIGH, {24'h0, v[15:8]});
      rd(`ADDR_STATUS, 32'h1);
      old = v;
    end
    setmode(6);
    irq <= 1'h1;
    run <= 1'h0;
    base <= ~old;
    pulse(3);
    chk("early", 32'h0, {31'h0, flag});
    pulse(1);
    repeat (6) @(posedge aclk);
    chk("wake", 32'h1, {31'h0, wake});
    rd(`ADDR_VALUE_LOW, {24'h0, old[7:0]});
    rd(`ADDR_STATUS, 32'h1);
    {run, irq, src_en} <= 3'h4;
    for (int m = 8; m < 12; m++)
    begin
      wr(`ADDR_MODE_CONTROL, 32'h0);
      repeat (3) @(posedge aclk);
      chk("pin", 32'h0, {31'h0, pout});
      v = 16'($urandom);
      base <= ~v;
      load <= 1'h1;
      wr(`ADDR_VALUE_LOW, {24'h0, v[7:0]});
      wr(`ADDR_VALUE_HIGH, {24'h0, v[15:8]});
      setmode(m);
      repeat (3) @(posedge aclk);
      chk("oe", m > 9, {31'h0, oe_n});
      if (m < 10) chk("preset", m == 9, {31'h0, pout});
      base <= v - 16'h0008;
      load <= 1'h1;
      @(posedge aclk);
      load <= 1'h0;
      repeat (16) @(posedge aclk);
      chk("flag", 32'h1, {31'h0, flag});
      if (m < 10) chk("match", m == 8, {31'h0, pout});
      chk("trig", m == 11, trigs);
    end
    conclude;
  end
endmodule  // tb_top
